// [include/wdt_pkg.sv]
// Constants shared by the watchdog and interval timer.
// Assumes a 32-bit byte-addressed register bus.
package wdt_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [31:0] ADDR_RELOAD = 32'hFFFF0360;
    localparam logic [31:0] ADDR_COUNT  = 32'hFFFF0364;
    localparam logic [31:0] ADDR_CTRL   = 32'hFFFF0368;
    localparam logic [31:0] ADDR_CLEAR  = 32'hFFFF036C;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [15:0] RELOAD_RST = 16'h0040;
    localparam logic [15:0] COUNT_RST  = 16'h0040;
    localparam logic [8:0]  CTRL_RST   = 9'h000;
    localparam logic [7:0]  PRE_RST    = 8'h00;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int BIT_PD_STOP  = 0;
    localparam int BIT_WD_IRQ   = 1;
    localparam int PRE_LO       = 2;
    localparam int BIT_WD_MODE  = 5;
    localparam int BIT_PERIODIC = 6;
    localparam int BIT_ENABLE   = 7;
    localparam int BIT_COUNT_UP = 8;
    // Bit 4 is reserved and reads as zero
    localparam logic [8:0] CTRL_MASK = 9'h1EF;

    // ----------------------------------------
    // Prescale selection and terminal counts
    // ----------------------------------------
    typedef enum logic [1:0] {
        PRE_DIV1   = 2'h0,
        PRE_DIV16  = 2'h1,
        PRE_DIV256 = 2'h2,
        PRE_RSVD   = 2'h3
    } prescale_t;
    localparam logic [7:0] PRE_TC_1   = 8'h00;
    localparam logic [7:0] PRE_TC_16  = 8'h0F;
    localparam logic [7:0] PRE_TC_256 = 8'hFF;

    // ----------------------------------------
    // Timing figures
    // ----------------------------------------
    localparam int LP_OSC_HZ     = 32768;
    localparam int MAX_TIMEOUT_S = 512;
    localparam int MIN_TIMEOUT_MS = 30;

endpackage

// [hw/watchdog_interval_timer.sv]
// Watchdog and interval timer with an Avalon-MM register slave.
// Assumes lp_osc_in is the free 32.768 kHz oscillator, sampled here,
// and that por_n is low only for a power-on reset.
//
// What this block does
// - Two modes: normal interval timing and watchdog recovery.
// - Setting control bit 5 enters watchdog mode.
// - Watchdog counts down from the reload value to zero.
// - Longest timeout 512 s with divide-by-256 and full reload.
// - At zero the watchdog resets the processor or interrupts, per bit 1.
// - Software writes clear register in time; watchdog then reloads.
// - Watchdog mode locks reload and control until power-on reset.
// - Non power-on resets leave the watchdog counting.
// - Counter halts while the debugger holds the core.
// - Runs in power-down unless control bit 0 is set.
// - Normal mode counts oscillator ticks divided by 1, 16 or 256.
// - On overflow the count reloads from the reload register if bit 6 is set; otherwise it wraps.
// - In normal mode a clear write drops the pending interrupt.
// - Reload and count are 16-bit; count is read only.
// - Control bits 3:2 pick prescale 1, 16, 256; 11 reserved.
// - Control bit 8 set counts up, clear counts down.
// - Bit 7 enables, bit 6 picks periodic or free-running.
// - With bit 1 set the watchdog zero raises an interrupt.
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_timer (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        por_n,
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        lp_osc_in,
    input  wire logic        debug_halt,
    input  wire logic        periph_powerdown,
    output logic             irq,
    output logic             wdt_reset_req
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (be[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    function automatic logic [7:0] prescale_tc(input logic [1:0] code);
        logic [7:0] tc;
        tc = wdt_pkg::PRE_TC_1;
        case (code)
            wdt_pkg::PRE_DIV16:  tc = wdt_pkg::PRE_TC_16;
            wdt_pkg::PRE_DIV256: tc = wdt_pkg::PRE_TC_256;
            default:             tc = wdt_pkg::PRE_TC_1;
        endcase
        return tc;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] reload_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [8:0]  ctrl_r;
    logic [7:0]  pre_r;
    logic        irq_r;
    logic        rst_req_r;
    logic        waitrequest_r;
    logic [31:0] readdata_r;
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic        lp_prev_r;

    logic wd_mode;
    logic timer_rst;
    logic bus_rst;
    logic wr_acc;
    logic svc_wr;
    logic ctrl_wr;
    logic reload_wr;
    logic halted;
    logic lp_edge;
    logic step;
    logic expire;
    logic [8:0] ctrl_new;
    logic [15:0] ctrl_merged;

    assign wd_mode = ctrl_r[wdt_pkg::BIT_WD_MODE];
    // Outside power-on, a running watchdog survives reset
    assign timer_rst = !por_n || (!rst_n && !wd_mode);
    assign bus_rst   = !por_n || !rst_n;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            sync1_r   <= 3'h0;
            sync2_r   <= 3'h0;
            lp_prev_r <= 1'b0;
        end else begin
            sync1_r   <= {lp_osc_in, debug_halt, periph_powerdown};
            sync2_r   <= sync1_r;
            lp_prev_r <= sync2_r[2];
        end
    end

    assign lp_edge = sync2_r[2] && !lp_prev_r;
    assign halted  = sync2_r[1]
                   || (sync2_r[0] && ctrl_r[wdt_pkg::BIT_PD_STOP]);

    // ----------------------------------------
    // Avalon-MM slave, one wait state
    // ----------------------------------------
    // Access takes effect at the edge where waitrequest is seen low
    assign wr_acc    = write && !waitrequest_r;
    assign svc_wr    = wr_acc && (address == wdt_pkg::ADDR_CLEAR);
    // Locked registers drop writes silently
    assign ctrl_wr   = wr_acc && (address == wdt_pkg::ADDR_CTRL)
                     && !wd_mode;
    assign reload_wr = wr_acc && (address == wdt_pkg::ADDR_RELOAD)
                     && !wd_mode;

    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            waitrequest_r <= 1'b1;
        end else if ((read || write) && waitrequest_r) begin
            waitrequest_r <= 1'b0;
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && waitrequest_r) begin
            if (address == wdt_pkg::ADDR_RELOAD) begin
                readdata_r <= {16'h0000, reload_r};
            end else if (address == wdt_pkg::ADDR_COUNT) begin
                readdata_r <= {16'h0000, count_r};
            end else if (address == wdt_pkg::ADDR_CTRL) begin
                readdata_r <= {23'h000000, ctrl_r & wdt_pkg::CTRL_MASK};
            end else begin
                readdata_r <= 32'h0000_0000;
            end
        end
    end

    // Only nine control bits exist; the upper lane bits are dropped
    assign ctrl_merged = merge16({7'h00, ctrl_r}, writedata, byteenable);
    assign ctrl_new    = ctrl_merged[8:0] & wdt_pkg::CTRL_MASK;

    // ----------------------------------------
    // Control and reload registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            ctrl_r <= wdt_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= ctrl_new;
        end
    end

    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            reload_r <= wdt_pkg::RELOAD_RST;
        end else if (reload_wr) begin
            reload_r <= merge16(reload_r, writedata, byteenable);
        end
    end

    // ----------------------------------------
    // Prescaler on oscillator ticks
    // ----------------------------------------
    logic running;
    logic [7:0] pre_tc;
    // Watchdog mode runs whatever the enable bit says
    assign running = wd_mode || ctrl_r[wdt_pkg::BIT_ENABLE];
    assign pre_tc  = prescale_tc(ctrl_r[wdt_pkg::PRE_LO +: 2]);
    assign step    = running && !halted && lp_edge
                   && (pre_r == pre_tc);

    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            pre_r <= wdt_pkg::PRE_RST;
        end else if (running && !halted && lp_edge) begin
            if (pre_r == pre_tc) begin
                pre_r <= wdt_pkg::PRE_RST;
            end else begin
                pre_r <= pre_r + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic start_load;
    // Leaving the idle state loads a fresh period
    assign start_load = ctrl_wr && !running
                      && (ctrl_new[wdt_pkg::BIT_ENABLE]
                          || ctrl_new[wdt_pkg::BIT_WD_MODE]);

    always_comb begin
        count_nxt = count_r;
        expire    = 1'b0;
        if (svc_wr && wd_mode) begin
            count_nxt = reload_r;
        end else if (start_load) begin
            count_nxt = reload_r;
        end else if (step) begin
            if (wd_mode) begin
                if (count_r <= 16'h0001) begin
                    expire    = 1'b1;
                    count_nxt = reload_r;
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end else if (ctrl_r[wdt_pkg::BIT_COUNT_UP]) begin
                if (count_r == 16'hFFFF) begin
                    expire    = 1'b1;
                    count_nxt = ctrl_r[wdt_pkg::BIT_PERIODIC] ? reload_r
                                                              : 16'h0000;
                end else begin
                    count_nxt = count_r + 16'h0001;
                end
            end else begin
                if (count_r == 16'h0000) begin
                    expire    = 1'b1;
                    count_nxt = ctrl_r[wdt_pkg::BIT_PERIODIC] ? reload_r
                                                              : 16'hFFFF;
                end else begin
                    count_nxt = count_r - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            count_r <= wdt_pkg::COUNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ----------------------------------------
    // Interrupt flag and reset request
    // ----------------------------------------
    logic irq_set;
    logic rst_set;
    assign irq_set = expire && (!wd_mode || ctrl_r[wdt_pkg::BIT_WD_IRQ]);
    assign rst_set = expire && wd_mode && !ctrl_r[wdt_pkg::BIT_WD_IRQ];

    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            irq_r <= 1'b0;
        end else begin
            // A timeout in the clearing cycle is kept
            irq_r <= (irq_r && !svc_wr) || irq_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (timer_rst) begin
            rst_req_r <= 1'b0;
        end else begin
            rst_req_r <= rst_set;
        end
    end

    assign readdata      = readdata_r;
    assign waitrequest   = waitrequest_r;
    assign irq           = irq_r;
    assign wdt_reset_req = rst_req_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n || !por_n);

    a_ctrl_locked: assert property (
        wd_mode && wr_acc && (address == wdt_pkg::ADDR_CTRL)
        |=> $stable(ctrl_r))
        else $error("control changed while locked");

    a_reload_locked: assert property (
        wd_mode && wr_acc && (address == wdt_pkg::ADDR_RELOAD)
        |=> reload_r == $past(reload_r))
        else $error("reload changed while locked");

    a_wd_survives: assert property (
        @(posedge core_clk) disable iff (!por_n)
        wd_mode && !rst_n |=> wd_mode && $stable(reload_r))
        else $error("watchdog lost on reset");

    a_wd_reset_out: assert property (
        step && wd_mode && (count_r <= 16'h0001) && !svc_wr
        && !ctrl_r[wdt_pkg::BIT_WD_IRQ]
        |=> wdt_reset_req ##1 !wdt_reset_req)
        else $error("watchdog reset pulse wrong");

    a_wd_irq_out: assert property (
        step && wd_mode && (count_r <= 16'h0001) && !svc_wr
        && ctrl_r[wdt_pkg::BIT_WD_IRQ]
        |=> irq && !wdt_reset_req)
        else $error("watchdog interrupt missing");

    a_service_reload: assert property (
        svc_wr && wd_mode |=> count_r == $past(reload_r) && !wdt_reset_req)
        else $error("service did not reload");

    a_debug_halt: assert property (
        sync2_r[1] && !wr_acc |=> $stable(count_r) && $stable(pre_r))
        else $error("counter moved while halted");

    a_pd_stop: assert property (
        sync2_r[0] && ctrl_r[wdt_pkg::BIT_PD_STOP] && !wr_acc
        |=> $stable(count_r))
        else $error("counter moved in power-down");

    a_irq_clear: assert property (
        irq && svc_wr && !wd_mode && !expire |=> !irq)
        else $error("clear write kept interrupt");

    a_irq_sticky: assert property (
        irq && !svc_wr |=> irq)
        else $error("interrupt dropped on its own");

    a_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

    c_wd_reset:  cover property (wdt_reset_req);
    c_wd_irq:    cover property (wd_mode && irq);
    c_norm_irq:  cover property (!wd_mode && irq ##[1:20] !irq);
    c_service:   cover property (svc_wr && wd_mode);

endmodule

`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the watchdog and interval timer.
// Assumes one wait cycle per register access and a fast oscillator pin.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [31:0] LD = wdt_pkg::ADDR_RELOAD;
    localparam logic [31:0] CT = wdt_pkg::ADDR_COUNT;
    localparam logic [31:0] CR = wdt_pkg::ADDR_CTRL;
    localparam logic [31:0] CL = wdt_pkg::ADDR_CLEAR;
    logic        core_clk = 1'b0;
    logic        rst_n;
    logic        por_n;
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        lp_osc_in;
    logic        debug_halt;
    logic        periph_powerdown;
    logic        irq;
    logic        wdt_reset_req;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          pulses = 0;
    logic [31:0] exp_q[$];

    watchdog_interval_timer dut (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .por_n            (por_n),
        .address          (address),
        .read             (read),
        .write            (write),
        .writedata        (writedata),
        .byteenable       (byteenable),
        .readdata         (readdata),
        .waitrequest      (waitrequest),
        .lp_osc_in        (lp_osc_in),
        .debug_halt       (debug_halt),
        .periph_powerdown (periph_powerdown),
        .irq              (irq),
        .wdt_reset_req    (wdt_reset_req)
    );

    always #5 core_clk = ~core_clk;

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic ci(input logic e);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic wrap_up();
        $display("Counts: %0d checked, %0d mismatched", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Read data are judged where waitrequest is sampled low
    always @(posedge core_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            chk(readdata, exp_q.pop_front());
        end
        if (wdt_reset_req === 1'b1) begin
            pulses <= pulses + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Bus and oscillator drivers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= w;
        read <= ~w;
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        // Gap edge so the next request never lands in the same step
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask

    task automatic tk(input int n);
        repeat (n) begin
            lp_osc_in <= 1'b1;
            repeat (4) @(posedge core_clk);
            lp_osc_in <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    task automatic idle(input logic [31:0] ld);
        wr(CR, 32'h00000000);
        wr(CL, 32'h00000000);
        wr(LD, ld);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int          tc[4];
        logic [31:0] r;
        tc = '{1, 16, 256, 1};
        rst_n = 1'b0;
        por_n = 1'b0;
        address = 32'h00000000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        lp_osc_in = 1'b0;
        debug_halt = 1'b0;
        periph_powerdown = 1'b0;
        void'($urandom(32'hD03474A4));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge core_clk);
        rd(LD, 32'h00000040);
        rd(CT, 32'h00000040);
        rd(CR, 32'h00000000);
        rd(CL, 32'h00000000);
        rd(32'hFFFF0370, 32'h00000000);
        r = $urandom();
        wr(LD, r);
        rd(LD, {16'h0000, r[15:0]});
        byteenable <= 4'h2;
        wr(LD, 32'h0000ABCD);
        byteenable <= 4'hF;
        rd(LD, {16'h0000, 8'hAB, r[7:0]});
        wr(CT, 32'h00001234);
        rd(CT, 32'h00000040);
        $display("Test done: register map");
        idle(32'h00000003);
        wr(CR, 32'h000000C0);
        tk(3);
        rd(CT, 32'h00000000);
        ci(1'b0);
        tk(1);
        ci(1'b1);
        rd(CT, 32'h00000003);
        tk(1);
        ci(1'b1);
        wr(CL, 32'h00000000);
        ci(1'b0);
        idle(32'h0000FFFE);
        wr(CR, 32'h00000180);
        tk(1);
        rd(CT, 32'h0000FFFF);
        ci(1'b0);
        tk(1);
        ci(1'b1);
        rd(CT, 32'h00000000);
        $display("Test done: normal modes");
        for (int i = 0; i < 4; i++) begin
            idle(32'h00000001);
            wr(CR, 32'h000000C0 | 32'(i << 2));
            tk(tc[i]);
            rd(CT, 32'h00000000);
            ci(1'b0);
            tk(tc[i]);
            ci(1'b1);
        end
        $display("Test done: prescale");
        idle(32'h00000005);
        wr(CR, 32'h000000C0);
        debug_halt <= 1'b1;
        repeat (4) @(posedge core_clk);
        tk(2);
        rd(CT, 32'h00000005);
        debug_halt <= 1'b0;
        repeat (4) @(posedge core_clk);
        tk(1);
        rd(CT, 32'h00000004);
        periph_powerdown <= 1'b1;
        repeat (4) @(posedge core_clk);
        tk(1);
        rd(CT, 32'h00000003);
        wr(CR, 32'h000000C1);
        tk(1);
        rd(CT, 32'h00000003);
        periph_powerdown <= 1'b0;
        $display("Test done: halt and power-down");
        idle(32'h00000004);
        wr(CR, 32'h00000028);
        tk(768);
        rd(CT, 32'h00000001);
        wr(CL, 32'h00000000);
        rd(CT, 32'h00000004);
        wr(LD, 32'h00000009);
        wr(CR, 32'h00000000);
        rd(LD, 32'h00000004);
        rd(CR, 32'h00000028);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(CR, 32'h00000028);
        tk(768);
        chk(32'(pulses), 32'h00000000);
        tk(256);
        chk(32'(pulses), 32'h00000001);
        rd(CT, 32'h00000004);
        // Only power-on reset may leave watchdog mode
        por_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        por_n <= 1'b1;
        @(posedge core_clk);
        rd(CR, 32'h00000000);
        rd(LD, 32'h00000040);
        wr(LD, 32'h00000004);
        wr(CR, 32'h0000002A);
        tk(1023);
        ci(1'b0);
        tk(1);
        ci(1'b1);
        chk(32'(pulses), 32'h00000001);
        wr(CL, 32'h00000000);
        ci(1'b0);
        $display("Test done: watchdog");
        repeat (2) @(posedge core_clk);
        chk(32'(exp_q.size()), 32'h00000000);
        wrap_up();
    end
endmodule
`default_nettype wire
